// ===== src/fpes_seq.v
`timescale 1ns/1ps
`include "fpes_regs.vh"

module fpes_seq #(
  parameter [31:0] PROG_CYCLES = `FPES_PROG_US * `FPES_CLK_MHZ,
  parameter [31:0] PAGE_ERASE_CYCLES = `FPES_PAGE_ERASE_US * `FPES_CLK_MHZ,
  parameter [31:0] SMALL_ERASE_CYCLES = `FPES_SMALL_ERASE_US * `FPES_CLK_MHZ,
  parameter [31:0] MEDIUM_ERASE_CYCLES = `FPES_MEDIUM_ERASE_US * `FPES_CLK_MHZ,
  parameter [31:0] LARGE_ERASE_CYCLES = `FPES_LARGE_ERASE_US * `FPES_CLK_MHZ,
  parameter [31:0] FULL_ERASE_CYCLES = `FPES_FULL_ERASE_US * `FPES_CLK_MHZ,
  parameter [31:0] PROG_HALT_CYCLES = `FPES_PROG_HALT_US * `FPES_CLK_MHZ,
  parameter [31:0] ERASE_HALT_CYCLES = `FPES_ERASE_HALT_US * `FPES_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial link pins
  input wire spi_cs_n,
  input wire spi_sck,
  input wire [3:0] spi_io_in,
  output wire [3:0] spi_io_out,
  output wire [3:0] spi_io_oe,
  // configuration
  input wire quad_lane_enable_bit,
  input wire [4:0] protect_range_bits,
  // status
  output wire operation_in_progress_bit,
  output wire write_enable_latch,
  output wire halted_operation_flag,
  output wire [15:0] status_word,
  // array program stream
  output wire arr_valid,
  input wire arr_ready,
  output wire [23:0] arr_addr,
  output wire [7:0] arr_data,
  // array erase request
  output wire erase_req,
  output wire [23:0] erase_base,
  output wire [23:0] erase_mask,
  // halted region
  output wire [23:0] halted_base,
  output wire [23:0] halted_mask
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PROG = 4'h2;
  localparam [3:0] ST_ERASE = 4'h4;
  localparam [3:0] ST_HWAIT = 4'h8;

  // ==========================================
  // pin synchronisers and edges
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg sck_d_reg;
  reg cs_d_reg;
  wire cs_hi = sync2_reg[0];
  wire sck_s = sync2_reg[1];
  wire [3:0] io_s = sync2_reg[5:2];
  wire sck_rise = sck_s & ~sck_d_reg & ~cs_hi;
  wire sck_fall = ~sck_s & sck_d_reg & ~cs_hi;
  wire cs_rise = cs_hi & ~cs_d_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 6'h01;
      sync2_reg <= 6'h01;
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {spi_io_in, spi_sck, spi_cs_n};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sck_s;
      cs_d_reg <= cs_hi;
    end
  end

  // ==========================================
  // frame shifter
  reg [7:0] sh_reg;
  reg [2:0] bcnt_reg;
  reg [2:0] frames_reg;
  reg [7:0] opcode_reg;
  reg [23:0] addr_reg;
  reg quad_reg;
  reg rd_act_reg;
  reg rd_hi_reg;
  reg [2:0] ocnt_reg;
  reg [7:0] pg_wr_idx_reg;
  reg [255:0] pg_mask_reg;
  reg [7:0] pg_mem [0:255];
  reg [3:0] io_out_reg;
  reg [3:0] io_oe_reg;
  reg [3:0] state_reg;
  reg halted_reg;
  reg h_prog_reg;
  reg [15:0] status_reg;

  wire [7:0] din = quad_reg ? {sh_reg[3:0], io_s} : {sh_reg[6:0], io_s[0]};
  wire [2:0] bcnt_n = bcnt_reg + (quad_reg ? 3'h4 : 3'h1);
  wire byte_done = sck_rise & (bcnt_n == 3'h0);
  wire busy_now = (state_reg != ST_IDLE);
  wire load_ok = quad_lane_enable_bit & ~busy_now & ~(halted_reg & h_prog_reg);
  wire data_wr = byte_done & (frames_reg >= 3'h4) & load_ok &
    (opcode_reg == `FPES_OP_PROG_QUAD);
  wire [7:0] rd_byte = rd_hi_reg ? status_reg[15:8] : status_reg[7:0];

  always @(posedge clk) begin
    if (data_wr) begin
      pg_mem[pg_wr_idx_reg] <= din;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      sh_reg <= 8'h00;
      bcnt_reg <= 3'h0;
      frames_reg <= 3'h0;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      quad_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
      ocnt_reg <= 3'h0;
      pg_wr_idx_reg <= 8'h00;
      pg_mask_reg <= {256{1'b0}};
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end else if (cs_hi) begin
      // opcode and address stay for the execute step on the rising select
      bcnt_reg <= 3'h0;
      frames_reg <= 3'h0;
      quad_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      ocnt_reg <= 3'h0;
      io_oe_reg <= 4'h0;
    end else begin
      if (sck_rise) begin
        sh_reg <= din;
        bcnt_reg <= bcnt_n;
      end
      if (byte_done) begin
        if (frames_reg != 3'h7) begin
          frames_reg <= frames_reg + 3'h1;
        end
        if (frames_reg == 3'h0) begin
          opcode_reg <= din;
          if (din == `FPES_OP_RD_SR_LO || din == `FPES_OP_RD_SR_HI) begin
            rd_act_reg <= 1'b1;
            rd_hi_reg <= (din == `FPES_OP_RD_SR_HI);
          end
          if (din == `FPES_OP_PROG_QUAD && load_ok) begin
            pg_mask_reg <= {256{1'b0}};
          end
        end else if (frames_reg <= 3'h3) begin
          addr_reg <= {addr_reg[15:0], din};
          if (frames_reg == 3'h3) begin
            pg_wr_idx_reg <= din;
            quad_reg <= quad_lane_enable_bit & (opcode_reg == `FPES_OP_PROG_QUAD);
          end
        end
        if (data_wr) begin
          // index wraps inside the page, so later bytes overwrite earlier ones
          pg_mask_reg[pg_wr_idx_reg] <= 1'b1;
          pg_wr_idx_reg <= pg_wr_idx_reg + 8'h01;
        end
      end
      if (sck_fall && rd_act_reg) begin
        io_out_reg <= {2'b00, rd_byte[3'h7 - ocnt_reg], 1'b0};
        io_oe_reg <= 4'h2;
        ocnt_reg <= ocnt_reg + 3'h1;
      end
    end
  end

  // ==========================================
  // command decode
  reg [23:0] cmd_mask;
  reg [31:0] cmd_cycles;
  reg cmd_erase;
  reg cmd_full;

  always @* begin
    cmd_mask = `FPES_MASK_PAGE;
    cmd_cycles = PAGE_ERASE_CYCLES;
    cmd_erase = 1'b1;
    cmd_full = 1'b0;
    case (opcode_reg)
      `FPES_OP_PAGE_ERASE_A, `FPES_OP_PAGE_ERASE_B: begin
        cmd_mask = `FPES_MASK_PAGE;
      end
      `FPES_OP_SMALL_ERASE: begin
        cmd_mask = `FPES_MASK_SMALL;
        cmd_cycles = SMALL_ERASE_CYCLES;
      end
      `FPES_OP_MEDIUM_ERASE: begin
        cmd_mask = `FPES_MASK_MEDIUM;
        cmd_cycles = MEDIUM_ERASE_CYCLES;
      end
      `FPES_OP_LARGE_ERASE: begin
        cmd_mask = `FPES_MASK_LARGE;
        cmd_cycles = LARGE_ERASE_CYCLES;
      end
      `FPES_OP_FULL_ERASE_A, `FPES_OP_FULL_ERASE_B: begin
        cmd_mask = `FPES_MASK_FULL;
        cmd_cycles = FULL_ERASE_CYCLES;
        cmd_full = 1'b1;
      end
      default: begin
        cmd_erase = 1'b0;
      end
    endcase
  end

  // count of protected 64 kB blocks, from the top or, with bit 4, the bottom
  function prot_hit;
    input [23:0] a;
    input [4:0] bp;
    reg [3:0] blk;
    begin
      blk = {2'b00, a[`FPES_BLK_HI:`FPES_BLK_LO]};
      if (bp[3:0] == 4'h0) begin
        prot_hit = 1'b0;
      end else if (bp[3:0] >= 4'h4) begin
        prot_hit = 1'b1;
      end else if (bp[4]) begin
        prot_hit = (blk < bp[3:0]);
      end else begin
        prot_hit = (blk >= 4'h4 - bp[3:0]);
      end
    end
  endfunction

  wire frame_ok = cs_rise & (bcnt_reg == 3'h0);
  wire addr_prot = prot_hit(addr_reg, protect_range_bits);
  wire any_prot = (protect_range_bits[3:0] != 4'h0);

  // ==========================================
  // operation sequencer
  reg wel_reg;
  reg rst_en_reg;
  reg busy_reg;
  reg [23:0] er_base_reg;
  reg [23:0] er_mask_reg;
  reg er_full_reg;
  reg [31:0] er_tmr_reg;
  reg [23:0] pg_base_reg;
  reg [7:0] pg_idx_reg;
  reg pg_stream_reg;
  reg [31:0] pg_tmr_reg;
  reg [31:0] hw_tmr_reg;
  reg erase_req_reg;
  reg [23:0] halted_base_reg;
  reg [23:0] halted_mask_reg;
  reg [15:0] status_next;
  wire buf_in_ready;
  wire buf_in_valid = (state_reg == ST_PROG) & pg_stream_reg & pg_mask_reg[pg_idx_reg];
  // guard against suspending in the very cycle an operation completes
  wire prog_halt_ok = (state_reg == ST_PROG) & ~halted_reg &
    (pg_stream_reg | (pg_tmr_reg > 32'h1));
  wire erase_halt_ok = (state_reg == ST_ERASE) & ~er_full_reg & (er_tmr_reg > 32'h1);
  wire prog_region_ok = ~halted_reg |
    (~h_prog_reg & ((addr_reg & ~er_mask_reg) != er_base_reg));

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      wel_reg <= 1'b0;
      halted_reg <= 1'b0;
      h_prog_reg <= 1'b0;
      rst_en_reg <= 1'b0;
      er_base_reg <= 24'h000000;
      er_mask_reg <= 24'h000000;
      er_full_reg <= 1'b0;
      er_tmr_reg <= 32'h0;
      pg_base_reg <= 24'h000000;
      pg_idx_reg <= 8'h00;
      pg_stream_reg <= 1'b0;
      pg_tmr_reg <= 32'h0;
      hw_tmr_reg <= 32'h0;
      erase_req_reg <= 1'b0;
      halted_base_reg <= 24'h000000;
      halted_mask_reg <= 24'h000000;
    end else begin
      erase_req_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
        end
        ST_PROG: begin
          if (pg_stream_reg) begin
            if (!pg_mask_reg[pg_idx_reg] || buf_in_ready) begin
              pg_idx_reg <= pg_idx_reg + 8'h01;
              if (pg_idx_reg == 8'hFF) begin
                pg_stream_reg <= 1'b0;
              end
            end
          end else if (pg_tmr_reg <= 32'h1) begin
            state_reg <= ST_IDLE;
            wel_reg <= 1'b0;
          end else begin
            pg_tmr_reg <= pg_tmr_reg - 32'h1;
          end
        end
        ST_ERASE: begin
          if (er_tmr_reg <= 32'h1) begin
            state_reg <= ST_IDLE;
            wel_reg <= 1'b0;
            erase_req_reg <= 1'b1;
          end else begin
            er_tmr_reg <= er_tmr_reg - 32'h1;
          end
        end
        ST_HWAIT: begin
          if (hw_tmr_reg <= 32'h1) begin
            state_reg <= ST_IDLE;
            wel_reg <= 1'b0;
            halted_reg <= 1'b1;
            halted_base_reg <= h_prog_reg ? pg_base_reg : er_base_reg;
            halted_mask_reg <= h_prog_reg ? `FPES_MASK_PAGE : er_mask_reg;
          end else begin
            hw_tmr_reg <= hw_tmr_reg - 32'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (frame_ok) begin
        rst_en_reg <= (opcode_reg == `FPES_OP_RST_ENABLE) & (frames_reg == 3'h1);
        if (opcode_reg == `FPES_OP_RST && frames_reg == 3'h1 && rst_en_reg) begin
          state_reg <= ST_IDLE;
          wel_reg <= 1'b0;
          halted_reg <= 1'b0;
          pg_stream_reg <= 1'b0;
        end else if (opcode_reg == `FPES_OP_LATCH_SET) begin
          if (frames_reg == 3'h1 && !busy_now && !(halted_reg && h_prog_reg)) begin
            wel_reg <= 1'b1;
          end
        end else if (opcode_reg == `FPES_OP_LATCH_CLR) begin
          if (frames_reg == 3'h1 && !busy_now) begin
            wel_reg <= 1'b0;
          end
        end else if (opcode_reg == `FPES_OP_HALT) begin
          if (frames_reg == 3'h1 && (prog_halt_ok || erase_halt_ok)) begin
            state_reg <= ST_HWAIT;
            h_prog_reg <= prog_halt_ok;
            hw_tmr_reg <= prog_halt_ok ? PROG_HALT_CYCLES : ERASE_HALT_CYCLES;
          end
        end else if (opcode_reg == `FPES_OP_RESUME) begin
          if (frames_reg == 3'h1 && halted_reg && !busy_now) begin
            halted_reg <= 1'b0;
            state_reg <= h_prog_reg ? ST_PROG : ST_ERASE;
          end
        end else if (cmd_erase) begin
          if (!busy_now && !halted_reg && wel_reg &&
              (cmd_full ? (frames_reg == 3'h1 && !any_prot)
                        : (frames_reg == 3'h4 && !addr_prot))) begin
            state_reg <= ST_ERASE;
            er_base_reg <= addr_reg & ~cmd_mask;
            er_mask_reg <= cmd_mask;
            er_full_reg <= cmd_full;
            er_tmr_reg <= cmd_cycles;
          end
        end else if (opcode_reg == `FPES_OP_PROG_QUAD) begin
          if (frames_reg >= 3'h5 && load_ok && wel_reg && !addr_prot && prog_region_ok) begin
            state_reg <= ST_PROG;
            pg_base_reg <= addr_reg & ~`FPES_MASK_PAGE;
            pg_idx_reg <= 8'h00;
            pg_stream_reg <= 1'b1;
            pg_tmr_reg <= PROG_CYCLES;
          end
        end
      end
    end
  end

  // ==========================================
  // status word
  always @* begin
    status_next = `FPES_SR_RESET;
    status_next[`FPES_SR_BUSY] = busy_now;
    status_next[`FPES_SR_WEL] = wel_reg;
    status_next[`FPES_SR_BP_LO+4:`FPES_SR_BP_LO] = protect_range_bits;
    status_next[`FPES_SR_QE] = quad_lane_enable_bit;
    status_next[`FPES_SR_HALT] = halted_reg;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      status_reg <= `FPES_SR_RESET;
      busy_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      busy_reg <= busy_now;
    end
  end

  // ==========================================
  // program stream buffer; a stalled array pauses the page walk
  wire [31:0] buf_out;

  fpes_buf2 #(
    .WIDTH(32)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({pg_base_reg[23:8], pg_idx_reg, pg_mem[pg_idx_reg]}),
    .out_valid(arr_valid),
    .out_ready(arr_ready),
    .out_data(buf_out)
  );

  assign arr_addr = buf_out[31:8];
  assign arr_data = buf_out[7:0];
  assign spi_io_out = io_out_reg;
  assign spi_io_oe = io_oe_reg;
  assign operation_in_progress_bit = busy_reg;
  assign write_enable_latch = wel_reg;
  assign halted_operation_flag = halted_reg;
  assign status_word = status_reg;
  assign erase_req = erase_req_reg;
  assign erase_base = er_base_reg;
  assign erase_mask = er_mask_reg;
  assign halted_base = halted_base_reg;
  assign halted_mask = halted_mask_reg;

endmodule

// ===== src/fpes_regs.vh
`ifndef FPES_REGS_VH
`define FPES_REGS_VH

// ==========================================
// clock
`define FPES_CLK_MHZ 125

// ==========================================
// opcodes
`define FPES_OP_LATCH_SET 8'h06
`define FPES_OP_LATCH_CLR 8'h04
`define FPES_OP_RD_SR_LO 8'h05
`define FPES_OP_RD_SR_HI 8'h35
`define FPES_OP_PROG_QUAD 8'h32
`define FPES_OP_PAGE_ERASE_A 8'h81
`define FPES_OP_PAGE_ERASE_B 8'hDB
`define FPES_OP_SMALL_ERASE 8'h20
`define FPES_OP_MEDIUM_ERASE 8'h52
`define FPES_OP_LARGE_ERASE 8'hD8
`define FPES_OP_FULL_ERASE_A 8'hC7
`define FPES_OP_FULL_ERASE_B 8'h60
`define FPES_OP_HALT 8'h75
`define FPES_OP_RESUME 8'h7A
`define FPES_OP_RST_ENABLE 8'h66
`define FPES_OP_RST 8'h99

// ==========================================
// ignored address bits per erase size
`define FPES_MASK_PAGE 24'h0000FF
`define FPES_MASK_SMALL 24'h000FFF
`define FPES_MASK_MEDIUM 24'h007FFF
`define FPES_MASK_LARGE 24'h00FFFF
`define FPES_MASK_FULL 24'hFFFFFF

// ==========================================
// status word bit positions
`define FPES_SR_BUSY 0
`define FPES_SR_WEL 1
`define FPES_SR_BP_LO 2
`define FPES_SR_QE 9
`define FPES_SR_HALT 15
`define FPES_SR_RESET 16'h0000

// ==========================================
// protection: 64 kB block index inside the array address
`define FPES_BLK_HI 17
`define FPES_BLK_LO 16

// ==========================================
// self-timed durations in microseconds
`define FPES_PROG_US 500
`define FPES_PAGE_ERASE_US 1000
`define FPES_SMALL_ERASE_US 1000
`define FPES_MEDIUM_ERASE_US 2000
`define FPES_LARGE_ERASE_US 4000
`define FPES_FULL_ERASE_US 8000
`define FPES_PROG_HALT_US 20
`define FPES_ERASE_HALT_US 20

`endif

// ===== src/fpes_buf2.v
`timescale 1ns/1ps

module fpes_buf2 #(
  parameter WIDTH = 32
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] head_reg;
  reg [WIDTH-1:0] tail_reg;
  reg head_v_reg;
  reg tail_v_reg;
  wire push;
  wire pop;

  // full only when both slots hold a word; no push-through when full
  assign in_ready = ~tail_v_reg;
  assign out_valid = head_v_reg;
  assign out_data = head_reg;
  assign push = in_valid & ~tail_v_reg;
  assign pop = head_v_reg & out_ready;

  always @(posedge clk) begin
    if (!rst_n) begin
      head_reg <= {WIDTH{1'b0}};
      tail_reg <= {WIDTH{1'b0}};
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
    end else if (pop) begin
      if (tail_v_reg) begin
        head_reg <= tail_reg;
        if (push) begin
          tail_reg <= in_data;
        end else begin
          tail_v_reg <= 1'b0;
        end
      end else if (push) begin
        head_reg <= in_data;
      end else begin
        head_v_reg <= 1'b0;
      end
    end else if (push) begin
      if (!head_v_reg) begin
        head_reg <= in_data;
        head_v_reg <= 1'b1;
      end else begin
        tail_reg <= in_data;
        tail_v_reg <= 1'b1;
      end
    end
  end

endmodule

// ===== sim/fpes_seq_props.sv
`timescale 1ns/1ps
// ==========================================
// port checks, bound to the sequencer
module fpes_seq_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link and configuration
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_oe,
  input wire logic quad_lane_enable_bit,
  input wire logic [4:0] protect_range_bits,
  // status
  input wire logic operation_in_progress_bit,
  input wire logic write_enable_latch,
  input wire logic halted_operation_flag,
  input wire logic [15:0] status_word,
  // array side
  input wire logic arr_valid,
  input wire logic arr_ready,
  input wire logic [23:0] arr_addr,
  input wire logic [7:0] arr_data,
  input wire logic erase_req,
  input wire logic [23:0] erase_base,
  input wire logic [23:0] erase_mask,
  input wire logic [23:0] halted_base,
  input wire logic [23:0] halted_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_erase_in_busy: assert property (erase_req |-> $past(operation_in_progress_bit))
    else $error("erase outside busy");
  a_busy_drops: assert property (erase_req |-> ##[1:2] !operation_in_progress_bit)
    else $error("busy held after erase");
  a_latch_cleared: assert property (erase_req |=> !write_enable_latch)
    else $error("latch kept after erase");
  a_erase_aligned: assert property (erase_req |-> (erase_base & erase_mask) == 24'h000000)
    else $error("erase base not aligned");
  a_mask_legal: assert property (erase_req |-> erase_mask inside {24'h0000FF,
    24'h000FFF, 24'h007FFF, 24'h00FFFF, 24'hFFFFFF}) else $error("erase size bad");
  a_chip_unprot: assert property (erase_req && erase_mask == 24'hFFFFFF |->
    protect_range_bits[3:0] == 4'h0) else $error("chip erase under protection");
  a_start_latched: assert property ($rose(operation_in_progress_bit) |->
    $past(write_enable_latch, 3) || $past(halted_operation_flag, 3)) else $error("no latch");
  a_halt_quiet: assert property ($rose(halted_operation_flag) |-> ##[0:2]
    (!write_enable_latch && !operation_in_progress_bit)) else $error("suspend not quiet");
  a_halt_status: assert property ($rose(halted_operation_flag) |-> ##[0:2] status_word[15])
    else $error("status bit 15 not set");
  a_halt_region: assert property (halted_operation_flag && $past(halted_operation_flag) |->
    halted_mask != 24'h0 && (halted_base & halted_mask) == 24'h0) else $error("halted region bad");
  a_resume_busy: assert property ($fell(halted_operation_flag) |-> ##[1:3] operation_in_progress_bit)
    else $error("resume did not restart");
  a_stream_hold: assert property (arr_valid && !arr_ready |=> arr_valid && $stable(arr_addr)
    && $stable(arr_data)) else $error("program byte dropped");
  a_quad_enabled: assert property ($rose(arr_valid) |-> quad_lane_enable_bit)
    else $error("program without quad enable");
  a_oe_released: assert property (spi_cs_n [*8] |-> spi_io_oe == 4'h0)
    else $error("io driven while deselected");
endmodule

bind fpes_seq fpes_seq_props u_props (.clk, .rst_n, .spi_cs_n, .spi_io_oe, .quad_lane_enable_bit,
  .protect_range_bits, .operation_in_progress_bit, .write_enable_latch, .halted_operation_flag,
  .status_word, .arr_valid, .arr_ready, .arr_addr, .arr_data, .erase_req, .erase_base,
  .erase_mask, .halted_base, .halted_mask);

// ===== sim/fpes_host_model.sv
`timescale 1ns/1ps
// ==========================================
// serial host, mode 0: sck only runs inside frames
module fpes_host_model (
  // link pins
  output logic cs_n,
  output logic sck,
  output logic [3:0] io,
  // wire level seen back
  input wire logic [3:0] io_line
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io = 4'h5;
  end
  // idle lanes toggle so a stale level never passes for data
  task automatic bit_out(input logic [3:0] v, input logic quad, output logic so);
    io = quad ? v : {~io[3:1], v[0]};
    #62.5 sck = 1'b1;
    so = io_line[1];
    #62.5 sck = 1'b0;
  endtask
  task automatic frame(input logic [39:0] hdr, input int nbits, input int ndata,
    output logic [7:0] rd);
    logic so;
    logic [7:0] b;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      bit_out({3'h0, hdr[39 - i]}, 1'b0, so);
      rd = {rd[6:0], so};
    end
    for (int i = 0; i < ndata; i++) begin
      b = i[7:0] ^ {i[8], 7'h00};
      bit_out(b[7:4], 1'b1, so);
      bit_out(b[3:0], 1'b1, so);
    end
    #30 cs_n = 1'b1;
    io = ~io;
    #60;
  endtask
endmodule

// ===== sim/test_flash_program_erase_sequencer.sv
`timescale 1ns/1ps
// ==========================================
// bench for the program and erase sequencer
module test_flash_program_erase_sequencer;
  typedef struct {
    logic [7:0] op;
    logic [23:0] a;
    int nb;
    logic [4:0] bp;
    logic go;
    logic [23:0] m;
  } fpes_row_t;
  logic clk, rst_n, quad_lane_enable_bit, arr_ready;
  logic [4:0] protect_range_bits;
  wire spi_cs_n, spi_sck, operation_in_progress_bit, write_enable_latch, halted_operation_flag;
  wire arr_valid, erase_req;
  wire [3:0] spi_io_in, spi_io_out, spi_io_oe, host_io;
  wire [15:0] status_word;
  wire [23:0] arr_addr, erase_base, erase_mask, halted_base, halted_mask;
  wire [7:0] arr_data;
  logic [7:0] mem [256];
  logic [23:0] er_base, er_mask;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int got_cnt = 0;
  int er_cnt = 0;
  fpes_row_t rows [11];

  assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & host_io);
  // short self-timed runs; both halt latencies keep their real length
  localparam [31:0] T_SHORT = 80, T_MID = 100, T_LONG = 200, T_FULL = 150;
  fpes_seq #(.PROG_CYCLES(T_MID), .PAGE_ERASE_CYCLES(T_SHORT), .SMALL_ERASE_CYCLES(T_SHORT),
    .MEDIUM_ERASE_CYCLES(T_MID), .LARGE_ERASE_CYCLES(T_LONG), .FULL_ERASE_CYCLES(T_FULL))
    u_dut (.clk, .rst_n, .spi_cs_n, .spi_sck,
    .spi_io_in, .spi_io_out, .spi_io_oe, .quad_lane_enable_bit, .protect_range_bits,
    .operation_in_progress_bit, .write_enable_latch, .halted_operation_flag, .status_word,
    .arr_valid, .arr_ready, .arr_addr, .arr_data, .erase_req, .erase_base, .erase_mask,
    .halted_base, .halted_mask);
  fpes_host_model u_host (.cs_n(spi_cs_n), .sck(spi_sck), .io(host_io), .io_line(spi_io_in));

  // ==========================================
  // clock, stalling array, timeout
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    arr_ready <= #1 (cyc % 3 != 0);
    if (cyc == 80000) begin
      error_cnt++;
      end_of_test();
    end
    if (arr_valid === 1'b1 && arr_ready) begin
      got_cnt++;
      mem[arr_addr[7:0]] = arr_data;
      check("program page", arr_addr[23:8], 16'h0100);
    end
    if (erase_req === 1'b1) begin
      er_cnt++;
      er_base = erase_base;
      er_mask = erase_mask;
    end
  end

  // ==========================================
  // tasks
  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [39:0] h, input int nbits);
    logic [7:0] d;
    u_host.frame(h, nbits, 0, d);
  endtask
  task automatic rd_status(output logic [15:0] s);
    logic [7:0] lo, hi;
    u_host.frame({8'h05, 32'h0}, 16, 0, lo);
    u_host.frame({8'h35, 32'h0}, 16, 0, hi);
    s = {hi, lo};
  endtask
  task automatic wait_idle(output logic [15:0] s);
    int k;
    k = 0;
    s = 16'h0001;
    while (s[0] !== 1'b0 && k < 60) begin
      rd_status(s);
      k++;
    end
    check("busy cleared", s[0], 1'b0);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [15:0] s;
    logic [7:0] d;
    logic [8:0] n;
    int n0, k;
    rst_n = 1'b0;
    quad_lane_enable_bit = 1'b0;
    protect_range_bits = 5'h00;
    arr_ready = 1'b0;
    rows = '{'{8'h81, 24'h0234AB, 4, 5'h00, 1'b1, 24'h0000FF},
      '{8'hDB, 24'h0301FF, 4, 5'h00, 1'b1, 24'h0000FF},
      '{8'h20, 24'h012FFF, 4, 5'h00, 1'b1, 24'h000FFF},
      '{8'h52, 24'h01FFFF, 4, 5'h00, 1'b1, 24'h007FFF},
      '{8'hD8, 24'h02ABCD, 4, 5'h00, 1'b1, 24'h00FFFF},
      '{8'hC7, 24'h000000, 1, 5'h00, 1'b1, 24'hFFFFFF},
      '{8'h60, 24'h000000, 1, 5'h00, 1'b1, 24'hFFFFFF},
      '{8'hD8, 24'h030000, 4, 5'h01, 1'b0, 24'h00FFFF},
      '{8'h20, 24'h001000, 4, 5'h11, 1'b0, 24'h000FFF},
      '{8'h20, 24'h021000, 4, 5'h11, 1'b1, 24'h000FFF},
      '{8'hC7, 24'h000000, 1, 5'h11, 1'b0, 24'hFFFFFF}};
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 check("status at reset", status_word, 16'h0000);
    foreach (rows[i]) begin
      @(posedge clk);
      #1 protect_range_bits = rows[i].bp;
      n0 = er_cnt;
      cmd({8'h06, 32'h0}, 8);
      cmd({rows[i].op, rows[i].a, 8'h00}, rows[i].nb * 8);
      wait_idle(s);
      check("erase done", 24'(er_cnt - n0), {23'h0, rows[i].go});
      if (rows[i].go) begin
        check("erase mask", er_mask, rows[i].m);
        check("erase base", er_base, rows[i].a & ~rows[i].m);
      end
      check("latch after", s[1], !rows[i].go);
    end
    // cut frame, then erase after the latch is dropped
    @(posedge clk);
    #1 protect_range_bits = 5'h00;
    n0 = er_cnt;
    cmd({8'h06, 32'h0}, 8);
    cmd({8'h20, 24'h004000, 8'h00}, 31);
    wait_idle(s);
    check("latch kept", s[1], 1'b1);
    cmd({8'h04, 32'h0}, 8);
    cmd({8'h20, 24'h004000, 8'h00}, 32);
    wait_idle(s);
    check("erases refused", 24'(er_cnt - n0), 24'h000000);
    // quad program, first without quad enable, then 258 bytes
    cmd({8'h06, 32'h0}, 8);
    u_host.frame({8'h32, 24'h0100F0, 8'h00}, 32, 4, d);
    wait_idle(s);
    check("quad refused", 24'(got_cnt), 24'h000000);
    @(posedge clk);
    #1 quad_lane_enable_bit = 1'b1;
    cmd({8'h06, 32'h0}, 8);
    u_host.frame({8'h32, 24'h0100F0, 8'h00}, 32, 258, d);
    wait_idle(s);
    check("bytes programmed", 24'(got_cnt), 24'h000100);
    for (int j = 0; j < 256; j++) begin
      n = {1'b0, 8'(j + 16)};
      if (n < 9'h002)
        n = n + 9'h100;
      check("program data", mem[j], n[7:0] ^ {n[8], 7'h00});
    end
    // suspend and resume of a block erase
    n0 = er_cnt;
    cmd({8'h06, 32'h0}, 8);
    cmd({8'hD8, 24'h01ABCD, 8'h00}, 32);
    cmd({8'h75, 32'h0}, 8);
    s = 16'h0000;
    k = 0;
    while (s[15] !== 1'b1 && k < 20) begin
      rd_status(s);
      k++;
    end
    // the low byte of that poll may predate the halt
    rd_status(s);
    check("halted flag", s[15], 1'b1);
    check("busy and latch", s[1:0], 2'b00);
    check("halted base", halted_base, 24'h010000);
    check("halted mask", halted_mask, 24'h00FFFF);
    check("no erase yet", 24'(er_cnt - n0), 24'h000000);
    cmd({8'h7A, 32'h0}, 8);
    repeat (15) @(posedge clk);
    #1 check("resume", {operation_in_progress_bit, halted_operation_flag}, 2'b10);
    wait_idle(s);
    check("erase resumed", 24'(er_cnt - n0), 24'h000001);
    check("halted cleared", s[15], 1'b0);
    // reset in the middle of a chip erase
    cmd({8'h06, 32'h0}, 8);
    cmd({8'hC7, 32'h0}, 8);
    repeat (30) @(posedge clk);
    #1 rst_n = 1'b0;
    n0 = er_cnt;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (200) @(posedge clk);
    #1 check("after reset", {operation_in_progress_bit, write_enable_latch}, 2'b00);
    check("erase aborted", 24'(er_cnt - n0), 24'h000000);
    end_of_test();
  end
endmodule
